// ---- rtl/gcsm_mux.sv ----
// Glitchless two-input clock switchover mux with bypass and amplitude-loss hold.
//
// How it works
// - With glitch elimination on, a switchover ends within 17 cycles of the new clock.
// - With glitch elimination off, the output follows the selected input at once.
// - A strap tied high at power-up selects bypass mode for good.
// - Both directions of switchover use the same staged sequence.
// - A selected input that loses amplitude freezes the output at its last level.
// - After a selection change the old clock still passes for a few of its pulses.
// - The output then stays low for a few new-clock pulses before the new clock passes.
// - If the old clock stopped high, the output stays high for a few new-clock pulses.
// - It then goes low for a few new falling edges before the new clock passes.
// - The selection input is synchronised, so stage lengths vary within limits.
// - A power-on delay puts the switchover logic in a known state first.
`default_nettype none
`include "gcsm_consts.svh"

module gcsm_mux #(
  parameter int DRAIN_PULSES = `GCSM_DRAIN_PULSES,
  parameter int HIGH_PULSES = `GCSM_HIGH_PULSES,
  parameter int LOW_EDGES = `GCSM_LOW_EDGES
) (
  input wire logic core_clk, // Core clock, 10 MHz.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic clock_input_zero, // Source clock zero.
  input wire logic clock_input_one, // Source clock one.
  input wire logic amp_ok_zero, // Input zero has valid amplitude.
  input wire logic amp_ok_one, // Input one has valid amplitude.
  input wire logic clock_select, // Selection, asynchronous.
  input wire logic reset_delay_strap, // High selects permanent bypass.
  output logic clock_out, // Switched clock.
  output logic active_input, // Input now driving the output.
  output logic switch_busy, // Staged switchover in progress.
  output logic amplitude_loss_hold, // Output frozen by amplitude loss.
  output logic glitch_elimination // Staged switchover enabled.
);

  // ========================================================================
  // Limits and elaboration checks
  localparam logic [`GCSM_CNT_W-1:0] POR_LAST = `GCSM_CNT_W'(`GCSM_POR_CYC);
  localparam logic [`GCSM_CNT_W-1:0] STALL_LIM = `GCSM_CNT_W'(`GCSM_STALL_CYC);
  localparam logic [`GCSM_STAGE_W-1:0] DRAIN_LAST = `GCSM_STAGE_W'(DRAIN_PULSES - 1);
  localparam logic [`GCSM_STAGE_W-1:0] HIGH_LAST = `GCSM_STAGE_W'(HIGH_PULSES - 1);
  localparam logic [`GCSM_STAGE_W-1:0] LOW_LAST = `GCSM_STAGE_W'(LOW_EDGES - 1);
  localparam logic [`GCSM_CNT_W-1:0] SW_MAX = `GCSM_CNT_W'(`GCSM_SWITCH_MAX_CYC);

  if (DRAIN_PULSES < 1 || HIGH_PULSES < 1 || LOW_EDGES < 1 ||
      DRAIN_PULSES > 8 || HIGH_PULSES > 8 || LOW_EDGES > 8 ||
      DRAIN_PULSES + HIGH_PULSES + LOW_EDGES + 4 > `GCSM_SWITCH_MAX_CYC)
  begin : g_bad_stage
    $error("gcsm_mux: stage counts cannot finish within the switchover limit");
  end

  if (`GCSM_POR_CYC >= 255 || `GCSM_STALL_CYC >= 255 || `GCSM_POR_CYC < 3)
  begin : g_bad_time
    $error("gcsm_mux: power-on or stall count out of counter range");
  end

  // ========================================================================
  // Input synchronisation and edge finding
  gcsm_pkg::gcsm_link_s link_raw;
  gcsm_pkg::gcsm_link_s link_q;
  logic [1:0] rise;
  logic [1:0] fall;

  always_comb
  begin
    link_raw.strap = reset_delay_strap;
    link_raw.sel = clock_select;
    link_raw.amp_ok = {amp_ok_one, amp_ok_zero};
    link_raw.clk = {clock_input_one, clock_input_zero};
  end

  gcsm_sync #(
    .W($bits(gcsm_pkg::gcsm_link_s))
  ) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .d_in(link_raw),
    .q_out(link_q)
  );

  for (genvar i = 0; i < 2; i++)
  begin : g_edge
    gcsm_edge u_edge (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .lvl(link_q.clk[i]),
      .rise(rise[i]),
      .fall(fall[i])
    );
  end

  // ========================================================================
  // Switchover core
  gcsm_pkg::gcsm_core_s core_reg;
  gcsm_pkg::gcsm_core_s core_next;
  logic amp_cur;
  logic stalled;

  assign amp_cur = link_q.amp_ok[core_reg.cur];
  assign stalled = core_reg.stall_cnt >= STALL_LIM;

  always_comb
  begin
    core_next = core_reg;
    core_next.hold = 1'b0;
    if (rise[core_reg.cur] || fall[core_reg.cur] || core_reg.state == gcsm_pkg::GCSM_ST_RUN)
    begin
      core_next.stall_cnt = '0;
    end
    else if (!stalled)
    begin
      core_next.stall_cnt = core_reg.stall_cnt + 1'b1;
    end
    if (core_reg.state != gcsm_pkg::GCSM_ST_RUN && rise[core_reg.tgt] && core_reg.sw_cnt != '1)
    begin
      core_next.sw_cnt = core_reg.sw_cnt + 1'b1;
    end
    if (!core_reg.por_done)
    begin
      core_next.out = 1'b0;
      core_next.cur = link_q.sel;
      core_next.tgt = link_q.sel;
      core_next.por_cnt = core_reg.por_cnt + 1'b1;
      if (core_reg.por_cnt == POR_LAST)
      begin
        core_next.por_done = 1'b1;
        core_next.bypass = link_q.strap;
      end
    end
    else if (core_reg.bypass)
    begin
      core_next.cur = link_q.sel;
      core_next.tgt = link_q.sel;
      if (link_q.amp_ok[link_q.sel])
      begin
        core_next.out = link_q.clk[link_q.sel];
      end
      else
      begin
        core_next.hold = 1'b1;
      end
    end
    else
    begin
      case (core_reg.state)
        gcsm_pkg::GCSM_ST_RUN:
        begin
          core_next.sw_cnt = '0;
          if (amp_cur)
          begin
            core_next.out = link_q.clk[core_reg.cur];
          end
          else
          begin
            core_next.hold = 1'b1;
          end
          if (link_q.sel != core_reg.cur)
          begin
            core_next.tgt = link_q.sel;
            core_next.stage_cnt = '0;
            core_next.state = gcsm_pkg::GCSM_ST_DRAIN;
          end
        end
        gcsm_pkg::GCSM_ST_DRAIN:
        begin
          if (link_q.sel == core_reg.cur)
          begin
            // An aborted switchover keeps passing the old clock without a gap.
            if (amp_cur)
            begin
              core_next.out = link_q.clk[core_reg.cur];
            end
            else
            begin
              core_next.hold = 1'b1;
            end
            core_next.state = gcsm_pkg::GCSM_ST_RUN;
          end
          else if (stalled || !amp_cur)
          begin
            core_next.hold = !amp_cur;
            core_next.stage_cnt = '0;
            if (core_reg.out)
            begin
              core_next.state = gcsm_pkg::GCSM_ST_HIGH;
            end
            else
            begin
              core_next.state = gcsm_pkg::GCSM_ST_LOW;
            end
          end
          else
          begin
            core_next.out = link_q.clk[core_reg.cur];
            if (fall[core_reg.cur])
            begin
              core_next.stage_cnt = core_reg.stage_cnt + 1'b1;
              if (core_reg.stage_cnt == DRAIN_LAST)
              begin
                core_next.stage_cnt = '0;
                core_next.out = 1'b0;
                core_next.state = gcsm_pkg::GCSM_ST_LOW;
              end
            end
          end
        end
        gcsm_pkg::GCSM_ST_HIGH:
        begin
          core_next.out = 1'b1;
          if (fall[core_reg.tgt])
          begin
            core_next.stage_cnt = core_reg.stage_cnt + 1'b1;
            if (core_reg.stage_cnt == HIGH_LAST)
            begin
              core_next.stage_cnt = '0;
              core_next.out = 1'b0;
              core_next.state = gcsm_pkg::GCSM_ST_LOW;
            end
          end
        end
        gcsm_pkg::GCSM_ST_LOW:
        begin
          core_next.out = 1'b0;
          if (fall[core_reg.tgt])
          begin
            core_next.stage_cnt = core_reg.stage_cnt + 1'b1;
            if (core_reg.stage_cnt == LOW_LAST)
            begin
              core_next.stage_cnt = '0;
              core_next.cur = core_reg.tgt;
              core_next.state = gcsm_pkg::GCSM_ST_RUN;
            end
          end
        end
        default:
        begin
          core_next.state = gcsm_pkg::GCSM_ST_RUN;
        end
      endcase
    end
    // Status outputs are registered copies of the next state.
    core_next.busy = core_next.state != gcsm_pkg::GCSM_ST_RUN;
    core_next.ge = core_next.por_done & ~core_next.bypass;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      core_reg <= '0;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  assign clock_out = core_reg.out;
  assign active_input = core_reg.cur;
  assign switch_busy = core_reg.busy;
  assign amplitude_loss_hold = core_reg.hold;
  assign glitch_elimination = core_reg.ge;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  logic sel_src;
  logic old_src;
  assign sel_src = link_q.clk[link_q.sel];
  assign old_src = link_q.clk[core_reg.cur];

  AST_SWITCH_LIMIT: assert property (
    core_reg.sw_cnt <= SW_MAX)
    else $error("switchover took more than the allowed new-clock cycles");

  AST_BYPASS_FOLLOW: assert property (
    core_reg.por_done && core_reg.bypass && link_q.amp_ok[link_q.sel]
    |=> core_reg.out == $past(sel_src))
    else $error("bypass output did not follow the selected input");

  AST_BYPASS_FIXED: assert property (
    core_reg.por_done && $past(core_reg.por_done)
    |-> $stable(core_reg.bypass) && (!core_reg.bypass || !switch_busy))
    else $error("bypass changed or staged sequence ran in bypass");

  AST_AMP_HOLD: assert property (
    core_reg.por_done && !core_reg.bypass && core_reg.state == gcsm_pkg::GCSM_ST_RUN
    && !amp_cur |=> core_reg.out == $past(core_reg.out) && core_reg.hold)
    else $error("output moved while the selected input had no amplitude");

  AST_DRAIN_FOLLOW: assert property (
    core_reg.state == gcsm_pkg::GCSM_ST_DRAIN && amp_cur && !stalled
    |=> core_reg.out == $past(old_src))
    else $error("old clock not passed during the first stage");

  AST_LOW_STAGE: assert property (
    core_reg.state == gcsm_pkg::GCSM_ST_LOW |-> !core_reg.out)
    else $error("output not low in the low stage");

  AST_HIGH_STAGE: assert property (
    core_reg.state == gcsm_pkg::GCSM_ST_HIGH
    |-> core_reg.out ##1 (core_reg.state inside {gcsm_pkg::GCSM_ST_HIGH, gcsm_pkg::GCSM_ST_LOW}))
    else $error("stopped-high stage left the output low or skipped the low stage");

  AST_LOW_EXIT: assert property (
    core_reg.state == gcsm_pkg::GCSM_ST_LOW ##1 core_reg.state == gcsm_pkg::GCSM_ST_RUN
    |-> core_reg.cur == $past(core_reg.tgt) && !core_reg.out)
    else $error("low stage did not hand over to the new clock");

  AST_POR_QUIET: assert property (
    !core_reg.por_done |-> !core_reg.out && !switch_busy)
    else $error("switchover logic active before power-on delay ended");

  AST_SEL_START: assert property (
    core_reg.por_done && !core_reg.bypass && core_reg.state == gcsm_pkg::GCSM_ST_RUN
    && link_q.sel != core_reg.cur
    |=> core_reg.state == gcsm_pkg::GCSM_ST_DRAIN && core_reg.tgt == $past(link_q.sel))
    else $error("selection change did not start a switchover to that input");

  COV_NORMAL: cover property (
    core_reg.state == gcsm_pkg::GCSM_ST_DRAIN ##1 core_reg.state == gcsm_pkg::GCSM_ST_LOW);
  COV_STUCK_HIGH: cover property (core_reg.state == gcsm_pkg::GCSM_ST_HIGH);
  COV_HOLD: cover property (core_reg.hold && !core_reg.bypass);
  COV_BYPASS: cover property (core_reg.bypass && $changed(core_reg.cur));

endmodule : gcsm_mux

`default_nettype wire

// ---- rtl/gcsm_consts.svh ----
// Constants of the glitchless clock switchover mux.
`ifndef GCSM_CONSTS_SVH
`define GCSM_CONSTS_SVH

// ==========================================================================
// Timing
`define GCSM_CLK_PERIOD_NS 100
`define GCSM_POR_TIME_NS 1000
`define GCSM_STALL_TIME_NS 2400
`define GCSM_POR_CYC ((`GCSM_POR_TIME_NS + `GCSM_CLK_PERIOD_NS - 1) / `GCSM_CLK_PERIOD_NS)
`define GCSM_STALL_CYC ((`GCSM_STALL_TIME_NS + `GCSM_CLK_PERIOD_NS - 1) / `GCSM_CLK_PERIOD_NS)

// ==========================================================================
// Stage lengths and limits
`define GCSM_DRAIN_PULSES 2
`define GCSM_HIGH_PULSES 2
`define GCSM_LOW_EDGES 2
`define GCSM_SWITCH_MAX_CYC 17

// ==========================================================================
// Widths and reset values
`define GCSM_CNT_W 8
`define GCSM_STAGE_W 3
`define GCSM_SYNC_RST 1'b0

`endif

// ---- rtl/gcsm_pkg.sv ----
// Types shared by the glitchless clock switchover mux.
`default_nettype none
`include "gcsm_consts.svh"

package gcsm_pkg;

  // ========================================================================
  // Switchover states, Gray coded along run, drain, low.
  typedef enum logic [1:0] {
    GCSM_ST_RUN   = 2'h0,
    GCSM_ST_DRAIN = 2'h1,
    GCSM_ST_LOW   = 2'h3,
    GCSM_ST_HIGH  = 2'h2
  } gcsm_state_e;

  // ========================================================================
  // Pin levels that cross into the core clock domain.
  typedef struct packed {
    logic strap;
    logic sel;
    logic [1:0] amp_ok;
    logic [1:0] clk;
  } gcsm_link_s;

  // ========================================================================
  // Whole state of the switchover core.
  typedef struct packed {
    gcsm_state_e state;
    logic [`GCSM_CNT_W-1:0] por_cnt;
    logic por_done;
    logic [`GCSM_CNT_W-1:0] stall_cnt;
    logic [`GCSM_STAGE_W-1:0] stage_cnt;
    logic [`GCSM_CNT_W-1:0] sw_cnt;
    logic cur;
    logic tgt;
    logic out;
    logic bypass;
    logic hold;
    logic busy;
    logic ge;
  } gcsm_core_s;

endpackage : gcsm_pkg

`default_nettype wire

// ---- rtl/gcsm_sync.sv ----
// Two flip-flop level synchroniser of configurable width.
`default_nettype none
`include "gcsm_consts.svh"

module gcsm_sync #(
  parameter int W = 1
) (
  input wire logic core_clk, // Core clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic [W-1:0] d_in, // Asynchronous levels.
  output logic [W-1:0] q_out // Levels in the core domain.
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gcsm_sync_s;

  gcsm_sync_s sync_reg;
  gcsm_sync_s sync_next;

  if (W < 1)
  begin : g_bad_w
    $error("gcsm_sync: width must be at least one");
  end

  always_comb
  begin
    sync_next.s1 = d_in;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      sync_reg <= {(2 * W){`GCSM_SYNC_RST}};
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  assign q_out = sync_reg.s2;

endmodule : gcsm_sync

`default_nettype wire

// ---- rtl/gcsm_edge.sv ----
// Edge finder for one sampled clock level.
`default_nettype none
`include "gcsm_consts.svh"

module gcsm_edge (
  input wire logic core_clk, // Core clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic lvl, // Synchronised clock level.
  output logic rise, // One-cycle pulse on a rising edge.
  output logic fall // One-cycle pulse on a falling edge.
);

  typedef struct packed {
    logic prev;
  } gcsm_edge_s;

  gcsm_edge_s edge_reg;
  gcsm_edge_s edge_next;

  always_comb
  begin
    edge_next.prev = lvl;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      edge_reg <= `GCSM_SYNC_RST;
    end
    else
    begin
      edge_reg <= edge_next;
    end
  end

  assign rise = lvl & ~edge_reg.prev;
  assign fall = ~lvl & edge_reg.prev;

endmodule : gcsm_edge

`default_nettype wire

// ---- verif/gcsm_src_model.sv ----
// Behavioural model of the two redundant clock sources.
`default_nettype none

module gcsm_src_model (
  input wire logic [1:0] stop_en, // Stop request per source.
  input wire logic [1:0] stop_lvl, // Level at which a stopped source rests.
  input wire logic [1:0] amp_in, // Amplitude valid per source.
  output logic [1:0] clk_src, // Source clocks.
  output logic [1:0] amp_ok // Amplitude flags.
);
  timeunit 1ns;
  timeprecision 1ns;

  // ========================================================================
  // Sources
  logic lvl [2];
  int tick [2];
  int lost [2];

  for (genvar i = 0; i < 2; i++)
  begin : g_src
    assign clk_src[i] = lvl[i];
    assign amp_ok[i] = amp_in[i];
    // A source without amplitude turns to noise after a short while.
    initial
    begin
      lvl[i] = 1'b0;
      tick[i] = 0;
      lost[i] = 0;
      #(150 * i + 1);
      forever
      begin
        #50;
        lost[i] = amp_in[i] ? 0 : lost[i] + 1;
        tick[i] = (tick[i] + 1) % 8;
        if (lost[i] > 8)
          lvl[i] = ~lvl[i];
        else if (tick[i] == 0 && !(stop_en[i] && lvl[i] == stop_lvl[i]))
          lvl[i] = ~lvl[i];
      end
    end
  end
endmodule : gcsm_src_model

`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking testbench of the glitchless clock switchover mux.
`default_nettype none
`include "gcsm_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // ========================================================================
  // Signals
  localparam int PER = 8;
  localparam int WIN = 64;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clock_select = 1'b0;
  logic [1:0] stop_en = 2'h0;
  logic [1:0] stop_lvl = 2'h0;
  logic [1:0] amp_in = 2'h3;
  logic [1:0] clk_src, amp_ok, c_out, act, busy, hold, ge;
  logic [31:0] rng = 32'h0000001a;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int run = 0;
  logic prev = 1'b0;
  logic mon_on = 1'b0;
  logic cur = 1'b0;
  logic first_out;
  int bc, rises, low_run, chg_at, n;

  always #50 core_clk = ~core_clk;

  gcsm_src_model gcsm_src_model_inst (.stop_en(stop_en), .stop_lvl(stop_lvl),
    .amp_in(amp_in), .clk_src(clk_src), .amp_ok(amp_ok));

  // Instance 0 stages its switchovers, instance 1 is strapped to bypass.
  for (genvar i = 0; i < 2; i++)
  begin : g_dut
    gcsm_mux gcsm_mux_inst (.core_clk(core_clk), .reset_n(reset_n),
      .clock_input_zero(clk_src[0]), .clock_input_one(clk_src[1]),
      .amp_ok_zero(amp_ok[0]), .amp_ok_one(amp_ok[1]), .clock_select(clock_select),
      .reset_delay_strap(i == 1), .clock_out(c_out[i]), .active_input(act[i]),
      .switch_busy(busy[i]), .amplitude_loss_hold(hold[i]), .glitch_elimination(ge[i]));
  end

  // ========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic int max_busy(input bit stuck);
    return (stuck ? `GCSM_STALL_CYC : 0) + PER + PER * (`GCSM_DRAIN_PULSES
      + `GCSM_HIGH_PULSES + `GCSM_LOW_EDGES);
  endfunction : max_busy

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task summarize;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic count_rises(input int k, output int cnt);
    logic p;
    cnt = 0;
    p = c_out[k];
    repeat (WIN)
    begin
      @(negedge core_clk);
      if (c_out[k] === 1'b1 && p === 1'b0) cnt++;
      p = c_out[k];
    end
  endtask : count_rises

  task automatic do_switch(input logic v, input bit stuck);
    int nr;
    logic po, pn;
    @(posedge core_clk);
    clock_select <= v;
    bc = 0;
    rises = 0;
    low_run = 0;
    chg_at = 0;
    nr = 0;
    repeat (4) @(negedge core_clk);
    first_out = c_out[0];
    po = c_out[0];
    pn = clk_src[v];
    check(busy[0], 1'b1);
    check(act[1], v);
    while (busy[0] === 1'b1 && bc < 300)
    begin
      @(negedge core_clk);
      bc++;
      if (c_out[0] === 1'b1 && po === 1'b0) rises++;
      if (clk_src[v] === 1'b1 && pn === 1'b0) nr++;
      if (chg_at == 0 && c_out[0] !== first_out) chg_at = bc;
      low_run = (c_out[0] === 1'b0) ? low_run + 1 : 0;
      po = c_out[0];
      pn = clk_src[v];
    end
    check(bc <= max_busy(stuck), 1'b1);
    check(nr <= `GCSM_SWITCH_MAX_CYC, 1'b1);
    check(act[0], v);
    check(low_run >= PER, 1'b1);
    if (!stuck) check(rises >= 1, 1'b1);
    cur = v;
  endtask : do_switch

  // ========================================================================
  // Short pulses on the staged output and the run time limit
  always @(negedge core_clk)
  begin
    if (c_out[0] !== prev)
    begin
      if (mon_on && ge[0] === 1'b1) check(run >= 3, 1'b1);
      run = 0;
    end
    run++;
    prev = c_out[0];
    if (busy[1] === 1'b1 && mon_on) check(busy[1], 1'b0);
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      num_errors++;
      summarize();
    end
  end

  // ========================================================================
  // Main sequence
  initial
  begin
    repeat (12) @(negedge core_clk);
    check(c_out, 2'h0);
    @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (5) @(negedge core_clk);
    check(c_out[0], 1'b0);
    repeat (20) @(negedge core_clk);
    check(ge, 2'h1);
    mon_on = 1'b1;
    count_rises(0, n);
    check(n, WIN / PER);
    $display("test reset done");
    for (int k = 0; k < 6; k++)
    begin
      rng = xs(rng);
      repeat (rng[5:0]) @(posedge core_clk);
      do_switch(~cur, 1'b0);
      count_rises(0, n);
      check(n, WIN / PER);
      count_rises(1, n);
      check(n, WIN / PER);
    end
    $display("test switchover done");
    @(posedge core_clk);
    clock_select <= ~cur;
    repeat (5) @(posedge core_clk);
    clock_select <= cur;
    repeat (8) @(negedge core_clk);
    check(busy[0], 1'b0);
    check(act[0], cur);
    count_rises(0, n);
    check(n, WIN / PER);
    $display("test aborted switchover done");
    for (int l = 0; l < 2; l++)
    begin
      @(posedge core_clk);
      stop_lvl[cur] <= l[0];
      stop_en[cur] <= 1'b1;
      repeat (40) @(negedge core_clk);
      do_switch(~cur, 1'b1);
      check(first_out, l[0]);
      check(rises, 0);
      if (l == 1) check(chg_at >= PER - 1, 1'b1);
      @(posedge core_clk);
      stop_en <= 2'h0;
      count_rises(0, n);
      check(n, WIN / PER);
    end
    $display("test stopped clock done");
    mon_on = 1'b0;
    @(posedge core_clk);
    amp_in[cur] <= 1'b0;
    repeat (5) @(negedge core_clk);
    check(hold[0], 1'b1);
    first_out = c_out[0];
    n = 0;
    repeat (32)
    begin
      @(negedge core_clk);
      if (c_out[0] !== first_out) n++;
    end
    check(n, 0);
    check(hold[0], 1'b1);
    @(posedge core_clk);
    amp_in <= 2'h3;
    repeat (16) @(negedge core_clk);
    check(hold[0], 1'b0);
    mon_on = 1'b1;
    do_switch(~cur, 1'b0);
    $display("test amplitude loss done");
    summarize();
  end
endmodule : testbench

`default_nettype wire
